// ---- hdl/fmsp_pkg.sv ----
`default_nettype none
// ==========================================================================
// shared constants of the four mode serial port
// ==========================================================================
package fmsp_pkg;
   // register bus geometry
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [1:0] ADDR_DATA = 2'h0;   // serial_data_buffer
   localparam logic [1:0] ADDR_CTRL = 2'h1;   // serial_control_reg
   localparam logic [1:0] ADDR_PWR  = 2'h2;   // power_control_reg
   // serial_control_reg fields
   localparam int CTRL_MSL = 7;               // mode_select_low
   localparam int CTRL_MSH = 6;               // mode_select_high
   localparam int CTRL_MPE = 5;               // multiproc_enable_bit
   localparam int CTRL_REN = 4;               // receive enable
   localparam int CTRL_TB8 = 3;               // transmit_ninth_bit
   localparam int CTRL_RB8 = 2;               // received_ninth_bit
   localparam int CTRL_TI  = 1;               // transmit_done_flag
   localparam int CTRL_RI  = 0;               // receive_done_flag
   // power_control_reg fields
   localparam int PWR_BD = 7;                 // baud_double_bit
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_RST  = 8'h00;
   // mode codes, {mode_select_high, mode_select_low}
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_T10  = 2'h1;
   localparam logic [1:0] MODE_O11  = 2'h2;
   localparam logic [1:0] MODE_T11  = 2'h3;
   // synchronous shift timing, in oscillator clocks
   localparam logic [3:0] M0_SLOW_LEAD = 4'h3;
   localparam logic [3:0] M0_SLOW_LOW  = 4'h6;
   localparam logic [3:0] M0_SLOW_PER  = 4'hc;
   localparam logic [3:0] M0_FAST_LEAD = 4'h1;
   localparam logic [3:0] M0_FAST_LOW  = 4'h2;
   localparam logic [3:0] M0_FAST_PER  = 4'h4;
   localparam logic [3:0] M0_LAST_BIT  = 4'h7;
   // oscillator prescale to the 16x tick: 2 or 4 clocks
   localparam logic [1:0] OSC_DIV_FAST = 2'h1;
   localparam logic [1:0] OSC_DIV_SLOW = 2'h3;
   // divide-by-16 counter states
   localparam logic [3:0] DIV16_LAST = 4'hf;
   localparam logic [3:0] SMP_FIRST  = 4'h7;  // 8th state
   localparam logic [3:0] SMP_LAST   = 4'h9;  // 10th state
   // frame lengths in bits
   localparam logic [3:0] FRAME_LEN10 = 4'ha;
   localparam logic [3:0] FRAME_LEN11 = 4'hb;
   localparam logic [3:0] RX_NINTH    = 4'h9;
   // state machines
   typedef enum logic [2:0] {
      M0_IDLE = 3'b001,
      M0_TX   = 3'b010,
      M0_RX   = 3'b100
   } fmsp_m0_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_BUSY = 2'b10
   } fmsp_rx_e;
endpackage
`default_nettype wire

// ---- hdl/fmsp_serial_port.sv ----
// Decided for this implementation: the register addresses and the strobed register port.
`default_nettype none
module fmsp_serial_port (
   // clock and reset
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          SRST_I,
   // register port
   input  wire logic [fmsp_pkg::ADDR_W-1:0]   REG_ADDR_I,
   input  wire logic [fmsp_pkg::DATA_W-1:0]   REG_WDATA_I,
   input  wire logic                          REG_WR_I,
   input  wire logic                          REG_RD_I,
   output logic      [fmsp_pkg::DATA_W-1:0]   REG_RDATA_O,
   // timer overflow pulse, same clock
   input  wire logic                          TMR_OVF_I,
   // serial pins
   input  wire logic                          RXD_I,
   output logic                               RXD_O,
   output logic                               RXD_OE_O,
   output logic                               TXD_O
);

   // =======================================================================
   // helpers
   // =======================================================================
   // two of three vote
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // =======================================================================
   // declarations
   // =======================================================================
   logic [7:0]          ctrl_q, ctrl_d;
   logic [7:0]          pwr_q;
   logic [7:0]          rbuf_q, rbuf_d;
   logic [7:0]          rdata_q;
   logic                rxd_m_q, rxd_s_q;
   logic [1:0]          pre_q;
   logic [3:0]          tx16_q, rx16_q;
   fmsp_pkg::fmsp_m0_e  m0_q;
   logic [3:0]          ph_q, m0_bits_q;
   logic                sclk_q, m0_dout_q;
   logic [10:0]         tx_sh_q;
   logic [3:0]          tx_cnt_q;
   logic                tx_busy_q, txd_q;
   fmsp_pkg::fmsp_rx_e  rx_q;
   logic [7:0]          rx_sh_q;
   logic [3:0]          rx_bit_q;
   logic [1:0]          smp_q;
   logic                rx_prev_q, rx_n9_q;

   // =======================================================================
   // register decode
   // =======================================================================
   wire logic [1:0] mode   = {ctrl_q[fmsp_pkg::CTRL_MSH], ctrl_q[fmsp_pkg::CTRL_MSL]};
   wire logic       mpe    = ctrl_q[fmsp_pkg::CTRL_MPE];
   wire logic       ren    = ctrl_q[fmsp_pkg::CTRL_REN];
   wire logic       ri     = ctrl_q[fmsp_pkg::CTRL_RI];
   wire logic       bd     = pwr_q[fmsp_pkg::PWR_BD];
   wire logic       wr_dat = REG_WR_I & (REG_ADDR_I == fmsp_pkg::ADDR_DATA);
   wire logic       wr_ctl = REG_WR_I & (REG_ADDR_I == fmsp_pkg::ADDR_CTRL);
   wire logic       wr_pwr = REG_WR_I & (REG_ADDR_I == fmsp_pkg::ADDR_PWR);
   wire logic       is_m0  = (mode == fmsp_pkg::MODE_SYNC);
   wire logic       has_n9 = mode[1];
   wire logic [3:0] flen   = has_n9 ? fmsp_pkg::FRAME_LEN11 : fmsp_pkg::FRAME_LEN10;

   // =======================================================================
   // register read, data valid only in the cycle after the strobe
   // =======================================================================
   // reads of the data address see the receive buffer
   wire logic [7:0] rd_mux =
      (REG_ADDR_I == fmsp_pkg::ADDR_DATA) ? rbuf_q :
      (REG_ADDR_I == fmsp_pkg::ADDR_CTRL) ? ctrl_q :
      (REG_ADDR_I == fmsp_pkg::ADDR_PWR)  ? {bd, 7'h00} : 8'h00;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= REG_RD_I ? rd_mux : 8'h00;
      end
   end
   assign REG_RDATA_O = rdata_q;

   // =======================================================================
   // input synchroniser
   // =======================================================================
   // rxd passes two flops before use
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
      end else begin
         rxd_m_q <= RXD_I;
         rxd_s_q <= rxd_m_q;
      end
   end

   // =======================================================================
   // 16x baud tick
   // =======================================================================
   wire logic [1:0] osc_lim = bd ? fmsp_pkg::OSC_DIV_FAST : fmsp_pkg::OSC_DIV_SLOW;
   // oscillator tick every 2 or 4 clocks -> 32 or 64 per bit
   wire logic osc_tick = (mode == fmsp_pkg::MODE_O11) & (pre_q == osc_lim);
   wire logic tmr_tick = mode[0] ? (TMR_OVF_I & (bd | pre_q[0])) : 1'b0;
   wire logic tick16   = osc_tick | tmr_tick;

   // prescaler for both clock sources
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pre_q <= 2'h0;
      end else if (mode == fmsp_pkg::MODE_O11) begin
         pre_q <= osc_tick ? 2'h0 : pre_q + 2'h1;
      end else if (TMR_OVF_I) begin
         pre_q <= {1'b0, ~pre_q[0]};
      end
   end

   // =======================================================================
   // synchronous shift mode
   // =======================================================================
   // period 12 or 4 clocks
   wire logic [3:0] m0_lead = mpe ? fmsp_pkg::M0_FAST_LEAD : fmsp_pkg::M0_SLOW_LEAD;
   wire logic [3:0] m0_low  = mpe ? fmsp_pkg::M0_FAST_LOW  : fmsp_pkg::M0_SLOW_LOW;
   wire logic [3:0] m0_per  = mpe ? fmsp_pkg::M0_FAST_PER  : fmsp_pkg::M0_SLOW_PER;
   wire logic [3:0] m0_rise = m0_lead + m0_low;
   wire logic       m0_act  = (m0_q != fmsp_pkg::M0_IDLE);
   wire logic       ph_end  = (ph_q == m0_per - 4'h1);
   wire logic       m0_last = m0_act & ph_end & (m0_bits_q == fmsp_pkg::M0_LAST_BIT);
   // reception starts when enabled and receive done clear
   wire logic       m0_rx_go = is_m0 & ren & ~ri & ~wr_dat & (m0_q == fmsp_pkg::M0_IDLE);
   wire logic [3:0] ph_d    = (~m0_act | ph_end) ? 4'h0 : ph_q + 4'h1;
   wire logic       m0_run  = m0_act | m0_rx_go | (is_m0 & wr_dat);
   // clock low from lead for low clocks
   wire logic       m0_lowin = m0_run & ~(m0_act & ph_end & m0_last) &
                               (ph_d >= m0_lead) & (ph_d < m0_rise);
   // latch at the rising shift clock edge
   wire logic       m0_latch = (m0_q == fmsp_pkg::M0_RX) & (ph_q == m0_rise);

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         m0_q      <= fmsp_pkg::M0_IDLE;
         ph_q      <= 4'h0;
         m0_bits_q <= 4'h0;
         sclk_q    <= 1'b1;
      end else begin
         ph_q   <= ph_d;
         sclk_q <= ~m0_lowin;
         case (m0_q)
            fmsp_pkg::M0_IDLE: begin
               m0_bits_q <= 4'h0;
               // a data write starts a sync transmission
               if (is_m0 & wr_dat) begin
                  m0_q <= fmsp_pkg::M0_TX;
               end else if (m0_rx_go) begin
                  m0_q <= fmsp_pkg::M0_RX;
               end
            end
            fmsp_pkg::M0_TX, fmsp_pkg::M0_RX: begin
               if (is_m0 & wr_dat) begin
                  m0_q      <= fmsp_pkg::M0_TX;
                  m0_bits_q <= 4'h0;
               end else if (m0_last) begin
                  m0_q <= fmsp_pkg::M0_IDLE;
               end else if (ph_end) begin
                  m0_bits_q <= m0_bits_q + 4'h1;
               end
            end
            default: begin
               m0_q <= fmsp_pkg::M0_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // transmitter
   // =======================================================================
   wire logic tx_roll = tick16 & (tx16_q == fmsp_pkg::DIV16_LAST);
   // stop bit driven at the final rollover
   wire logic tx_done = ~is_m0 & tx_busy_q & tx_roll & (tx_cnt_q == flen - 4'h1);
   // ninth bit from the control register in modes 2 and 3
   wire logic n9_bit  = has_n9 ? ctrl_q[fmsp_pkg::CTRL_TB8] : 1'b1;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         tx16_q    <= 4'h0;
         tx_sh_q   <= '1;
         tx_cnt_q  <= 4'h0;
         tx_busy_q <= 1'b0;
         txd_q     <= 1'b1;
         m0_dout_q <= 1'b1;
      end else begin
         if (tick16) begin
            tx16_q <= tx16_q + 4'h1;
         end
         if (wr_dat) begin
            // a data write loads the transmit register
            tx_sh_q   <= {1'b1, n9_bit, REG_WDATA_I, 1'b0};
            tx_cnt_q  <= 4'h0;
            tx_busy_q <= ~is_m0;
            m0_dout_q <= REG_WDATA_I[0];
         end else if (is_m0) begin
            // lsb first, next bit after the rising edge
            if ((m0_q == fmsp_pkg::M0_TX) & ph_end) begin
               tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
               m0_dout_q <= tx_sh_q[2];
            end
         end else if (tx_busy_q & tx_roll) begin
            txd_q     <= tx_sh_q[0];
            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q  <= tx_cnt_q + 4'h1;
            tx_busy_q <= ~tx_done;
         end
      end
   end

   // =======================================================================
   // asynchronous receiver
   // =======================================================================
   // falling edge seen at the 16x rate
   wire logic rx_edge  = ~is_m0 & ren & tick16 & rx_prev_q & ~rxd_s_q &
                         (rx_q == fmsp_pkg::RX_IDLE);
   // vote when the 10th state is sampled
   wire logic rx_dec   = (rx_q == fmsp_pkg::RX_BUSY) & tick16 &
                         (rx16_q == fmsp_pkg::SMP_LAST);
   wire logic rx_val   = maj3(smp_q[1], smp_q[0], rxd_s_q);
   wire logic rx_end   = rx_dec & (rx_bit_q == flen - 4'h1);
   // stop or ninth bit goes to the ninth flag
   wire logic rb8_val  = has_n9 ? rx_n9_q : rx_val;
   // load only if done clear and multiproc check passes
   wire logic rx_load  = rx_end & ~ri & (~mpe | rb8_val);
   wire logic m0_load  = m0_last & (m0_q == fmsp_pkg::M0_RX) & ~wr_dat;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rx_q      <= fmsp_pkg::RX_IDLE;
         rx16_q    <= 4'h0;
         rx_bit_q  <= 4'h0;
         smp_q     <= 2'h3;
         rx_prev_q <= 1'b1;
         rx_n9_q   <= 1'b0;
         rx_sh_q   <= 8'h00;
      end else begin
         if (tick16) begin
            rx_prev_q <= rxd_s_q;
         end
         if (m0_latch) begin
            rx_sh_q <= {rxd_s_q, rx_sh_q[7:1]};
         end
         case (rx_q)
            fmsp_pkg::RX_IDLE: begin
               rx_bit_q <= 4'h0;
               if (rx_edge) begin
                  rx_q   <= fmsp_pkg::RX_BUSY;
                  rx16_q <= 4'h0;
               end
            end
            fmsp_pkg::RX_BUSY: begin
               if (tick16) begin
                  rx16_q <= rx16_q + 4'h1;
               end
               if (tick16 & (rx16_q >= fmsp_pkg::SMP_FIRST)) begin
                  smp_q <= {smp_q[0], rxd_s_q};
               end
               if (is_m0 | ~ren) begin
                  rx_q <= fmsp_pkg::RX_IDLE;
               end else if (rx_dec) begin
                  rx_bit_q <= rx_bit_q + 4'h1;
                  if ((rx_bit_q != 4'h0) & (rx_bit_q < fmsp_pkg::RX_NINTH)) begin
                     rx_sh_q <= {rx_val, rx_sh_q[7:1]};
                  end
                  if (rx_bit_q == fmsp_pkg::RX_NINTH) begin
                     rx_n9_q <= rx_val;
                  end
                  // back to edge search after the stop middle
                  if (((rx_bit_q == 4'h0) & rx_val) | rx_end) begin
                     rx_q <= fmsp_pkg::RX_IDLE;
                  end
               end
            end
            default: begin
               rx_q <= fmsp_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // receive buffer and control registers
   // =======================================================================
   // receive buffer takes the frame data
   always_comb begin
      rbuf_d = rbuf_q;
      if (rx_load) begin
         rbuf_d = rx_sh_q;
      end else if (m0_load) begin
         rbuf_d = rx_sh_q;
      end
   end

   // software fields, then hardware sets win over clears
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctl) begin
         ctrl_d[7:2] = REG_WDATA_I[7:2];
         // done flags only clear on a control write
         ctrl_d[fmsp_pkg::CTRL_TI] = ctrl_q[fmsp_pkg::CTRL_TI] & REG_WDATA_I[fmsp_pkg::CTRL_TI];
         ctrl_d[fmsp_pkg::CTRL_RI] = ctrl_q[fmsp_pkg::CTRL_RI] & REG_WDATA_I[fmsp_pkg::CTRL_RI];
      end
      if (tx_done | (m0_last & (m0_q == fmsp_pkg::M0_TX) & ~wr_dat)) begin
         ctrl_d[fmsp_pkg::CTRL_TI] = 1'b1;
      end
      if (m0_load | rx_load) begin
         ctrl_d[fmsp_pkg::CTRL_RI] = 1'b1;
      end
      if (rx_load) begin
         ctrl_d[fmsp_pkg::CTRL_RB8] = rb8_val;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         ctrl_q <= fmsp_pkg::CTRL_RST;
         pwr_q  <= fmsp_pkg::PWR_RST;
         rbuf_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         rbuf_q <= rbuf_d;
         if (wr_pwr) begin
            pwr_q <= REG_WDATA_I & 8'h80;
         end
      end
   end

   // =======================================================================
   // pins
   // =======================================================================
   // sync: clock on txd, data on rxd only while sending
   assign TXD_O    = is_m0 ? sclk_q : txd_q;
   assign RXD_O    = m0_dout_q;
   assign RXD_OE_O = is_m0 & (m0_q == fmsp_pkg::M0_TX);

endmodule // fmsp_serial_port
`default_nettype wire

// ---- testbench/fmsp_serial_port_props.sv ----
`default_nettype none
// ==========================================
// port checker of the serial port
// ==========================================
module fmsp_serial_port_props (
   // clock and reset
   input wire logic       CLK_SYS_I,
   input wire logic       SRST_I,
   // register port
   input wire logic [1:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic       REG_WR_I,
   input wire logic       REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   // serial pins
   input wire logic       TXD_O,
   input wire logic       RXD_O,
   input wire logic       RXD_OE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   logic [7:0] ctrl_q;
   logic       bd_q;
   // address decode and mode view of the shadow
   wire logic wr_ctl = REG_WR_I && REG_ADDR_I == fmsp_pkg::ADDR_CTRL;
   wire logic wr_pwr = REG_WR_I && REG_ADDR_I == fmsp_pkg::ADDR_PWR;
   wire logic wr_dat = REG_WR_I && REG_ADDR_I == fmsp_pkg::ADDR_DATA;
   wire logic mode0  = ctrl_q[7:6] == 2'h0;
   wire logic mode2  = ctrl_q[6] && !ctrl_q[7];
   wire logic fast   = ctrl_q[5];
   // shadow of the software-written bits
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         ctrl_q <= 8'h00;
         bd_q   <= 1'b0;
      end else begin
         if (wr_ctl) ctrl_q <= REG_WDATA_I;
         if (wr_pwr) bd_q <= REG_WDATA_I[7];
      end
   end
   // shift clock low phase, fast and slow
   sequence s_low_fast;
      !TXD_O [*2] ##1 TXD_O;
   endsequence
   sequence s_low_slow;
      !TXD_O [*6] ##1 TXD_O;
   endsequence
   a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
      else $error("read data not zero outside read");
   a_unmapped_rd: assert property (REG_RD_I && REG_ADDR_I == 2'h3 |=> REG_RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_rd: assert property (REG_RD_I && REG_ADDR_I == fmsp_pkg::ADDR_CTRL
      |=> REG_RDATA_O[7:3] == ctrl_q[7:3]) else $error("control readback wrong");
   a_pwr_rd: assert property (REG_RD_I && REG_ADDR_I == fmsp_pkg::ADDR_PWR
      |=> REG_RDATA_O == {bd_q, 7'h00}) else $error("power readback wrong");
   a_m0_start: assert property (wr_dat && mode0 && REG_WDATA_I[0]
      |=> RXD_OE_O && RXD_O) else $error("sync transmit did not start");
   a_oe_mode0: assert property (RXD_OE_O |-> mode0)
      else $error("data pin driven outside sync mode");
   a_m0_low_fast: assert property ($fell(TXD_O) && RXD_OE_O && fast |-> s_low_fast)
      else $error("fast shift clock low time wrong");
   a_m0_low_slow: assert property ($fell(TXD_O) && RXD_OE_O && !fast |-> s_low_slow)
      else $error("slow shift clock low time wrong");
   a_async_start: assert property (wr_dat && mode2 && bd_q |-> ##[1:40] !TXD_O)
      else $error("start bit late");
endmodule // fmsp_serial_port_props
`default_nettype wire

// ---- testbench/fmsp_peer.sv ----
`default_nettype none
// ==========================================
// remote node driving the receive line
// ==========================================
module fmsp_peer (
   // clock and shift clock
   input  wire logic clk_i,
   input  wire logic txd_i,
   // line towards the port, pulled up
   output var  logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       m0_en = 1'b0;
   logic [7:0] m0_byte = 8'h00;
   int         m0_idx = 0;
   logic       txd_q = 1'b1;
   initial rxd_o = 1'b1;
   // data changes on shift clock fall
   always @(posedge clk_i) begin
      txd_q <= txd_i;
      if (m0_en && txd_q && !txd_i && m0_idx < 8) begin
         rxd_o  <= m0_byte[m0_idx];
         m0_idx <= m0_idx + 1;
      end else if (m0_en && m0_idx == 8 && txd_i) begin
         rxd_o <= 1'b1; // released, pull-up wins
         m0_en <= 1'b0;
      end
   end
   // arm a byte for a sync receive
   task automatic arm(input logic [7:0] d);
      m0_byte <= d;
      m0_idx  <= 0;
      m0_en   <= 1'b1;
   endtask
   // async frame, bit 0 first, per clocks per bit
   task automatic send(input logic [10:0] bits, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         rxd_o <= bits[i];
         repeat (per) @(posedge clk_i);
      end
      rxd_o <= 1'b1;
   endtask
endmodule // fmsp_peer
`default_nettype wire

// ---- testbench/fmsp_serial_port_tb_top.sv ----
`default_nettype none
// ==========================================
// top bench of the serial port
// ==========================================
module fmsp_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, srst, wr, rd, txd, rxd_o, rxd_oe, peer_rxd;
   logic       ovf = 1'b0;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, v, b, c;
   logic       n9;
   int         n_errors, tests_run;
   int         ovf_cnt = 0;
   wire  logic rxd_line = rxd_oe ? rxd_o : peer_rxd;
   fmsp_serial_port u_dut (.CLK_SYS_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .TMR_OVF_I(ovf), .RXD_I(rxd_line), .RXD_O(rxd_o), .RXD_OE_O(rxd_oe), .TXD_O(txd));
   fmsp_peer u_peer (.clk_i(clk), .txd_i(txd), .rxd_o(peer_rxd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // timer overflow pulse every 4 clocks
   always @(posedge clk) begin
      ovf_cnt <= (ovf_cnt + 1) % 4;
      ovf     <= ovf_cnt == 3;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded wait for a shift clock or line level
   task automatic wait_txd(input logic lvl);
      int k;
      k = 0;
      while (txd !== lvl && k < 200) begin
         @(posedge clk);
         #1 k++;
      end
      check({7'h0, k < 200}, 8'h01);
   endtask
   task automatic t_m0_tx(input logic fst);
      b = 8'($urandom);
      wreg(fmsp_pkg::ADDR_CTRL, {2'h0, fst, 5'h00});
      wreg(fmsp_pkg::ADDR_DATA, b);
      for (int i = 0; i < 8; i++) begin
         wait_txd(1'b0);
         wait_txd(1'b1);
         check({7'h0, rxd_o}, {7'h0, b[i]});
      end
      repeat (20) @(posedge clk);
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h02, 8'h02);
      check({7'h0, rxd_oe}, 8'h00);
      $display("test sync transmit done");
   endtask
   task automatic t_async_tx(input logic [1:0] m, input logic bd, input int per);
      logic [10:0] f;
      int          n;
      b = 8'($urandom);
      n9 = 1'($urandom);
      n = (m == fmsp_pkg::MODE_T10) ? 10 : 11;
      f = (m == fmsp_pkg::MODE_T10) ? {2'b11, b, 1'b0} : {1'b1, n9, b, 1'b0};
      wreg(fmsp_pkg::ADDR_PWR, {bd, 7'h00});
      wreg(fmsp_pkg::ADDR_CTRL, {m[0], m[1], 2'h0, n9, 3'h0});
      wreg(fmsp_pkg::ADDR_DATA, b);
      wait_txd(1'b0);
      repeat (per / 2) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         check({7'h0, txd}, {7'h0, f[i]});
         repeat (per) @(negedge clk);
      end
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h02, 8'h02);
      $display("test async transmit done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #200_000;
      n_errors++;
      end_sim();
   end
   initial begin
      srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 8'h00;
      n_errors = 0; tests_run = 0;
      void'($urandom(32'hea30100f));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      // reset values, unmapped and partial registers
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v, fmsp_pkg::CTRL_RST);
      wreg(2'h3, 8'($urandom));
      rreg(2'h3, v);
      check(v, 8'h00);
      wreg(fmsp_pkg::ADDR_PWR, 8'hff);
      rreg(fmsp_pkg::ADDR_PWR, v);
      check(v, 8'h80);
      $display("test registers done");
      t_m0_tx(1'b1);
      t_m0_tx(1'b0);
      // sync receive, slow clock
      c = 8'($urandom);
      u_peer.arm(c);
      wreg(fmsp_pkg::ADDR_CTRL, 8'h10);
      repeat (150) @(posedge clk);
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h01, 8'h01);
      rreg(fmsp_pkg::ADDR_DATA, v);
      check(v, c);
      $display("test sync receive done");
      t_async_tx(fmsp_pkg::MODE_T10, 1'b1, 64);
      t_async_tx(fmsp_pkg::MODE_T10, 1'b0, 128);
      t_async_tx(fmsp_pkg::MODE_O11, 1'b1, 32);
      t_async_tx(fmsp_pkg::MODE_O11, 1'b0, 64);
      t_async_tx(fmsp_pkg::MODE_T11, 1'b1, 64);
      // async receive in mode 2 at 32 clocks a bit
      wreg(fmsp_pkg::ADDR_PWR, 8'h80);
      wreg(fmsp_pkg::ADDR_CTRL, 8'h50);
      b = 8'($urandom);
      n9 = 1'($urandom);
      u_peer.send({1'b1, n9, b, 1'b0}, 11, 32);
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h05, {5'h0, n9, 2'b01});
      rreg(fmsp_pkg::ADDR_DATA, v);
      check(v, b);
      u_peer.send({2'b11, ~b, 1'b0}, 11, 32);
      rreg(fmsp_pkg::ADDR_DATA, v);
      check(v, b);
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h01, 8'h01);
      wreg(fmsp_pkg::ADDR_CTRL, 8'h70);
      u_peer.send(11'h7fe, 2, 4);
      repeat (60) @(posedge clk);
      u_peer.send({2'b10, ~b, 1'b0}, 11, 32);
      rreg(fmsp_pkg::ADDR_CTRL, v);
      check(v & 8'h01, 8'h00);
      c = 8'($urandom);
      u_peer.send({2'b11, c, 1'b0}, 11, 32);
      rreg(fmsp_pkg::ADDR_DATA, v);
      check(v, c);
      $display("test async receive done");
      end_sim();
   end
endmodule // fmsp_serial_port_tb_top
bind fmsp_serial_port fmsp_serial_port_props u_props (.CLK_SYS_I(CLK_SYS_I),
   .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .TXD_O(TXD_O), .RXD_O(RXD_O), .RXD_OE_O(RXD_OE_O));
`default_nettype wire
